// File: lane_steer_pkg.sv
`default_nettype none
package lane_steer_pkg;
   // widths of the request and of the external bus
   localparam int ADDR_W     = 3;
   localparam int SIZE_W     = 3;
   localparam int HDATA_W    = 64;
   localparam int EXT_DATA_W = 16;
   localparam int STRB_W     = 2;
   localparam int CNT_W      = 4;
   localparam int BYTE_W     = 8;
   localparam int HALF_W     = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int ENTRY_W    = 1 + SIZE_W + ADDR_W + HDATA_W;

   // transfer size codes on the request side
   localparam logic [SIZE_W-1:0] SIZE_BYTE  = 3'h0;
   localparam logic [SIZE_W-1:0] SIZE_HALF  = 3'h1;
   localparam logic [SIZE_W-1:0] SIZE_WORD  = 3'h2;
   localparam logic [SIZE_W-1:0] SIZE_DWORD = 3'h3;

   // active-low strobe patterns, bit 1 = lane [15:8], bit 0 = lane [7:0]
   localparam logic [STRB_W-1:0] STRB_BOTH   = 2'h0;
   localparam logic [STRB_W-1:0] STRB_UPPER  = 2'h1;
   localparam logic [STRB_W-1:0] STRB_LOWER  = 2'h2;
   localparam logic [STRB_W-1:0] STRB_NONE   = 2'h3;

   // misc small constants
   localparam logic [CNT_W-1:0]  CNT_ONE  = 4'h1;
   localparam logic [ADDR_W-1:0] IDX_ONE  = 3'h1;
   localparam logic [BYTE_W-1:0] LANE_PAD = 8'h00;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } seq_state_t;
endpackage : lane_steer_pkg
`default_nettype wire

// File: narrow_bus_write_lane_steering.sv
`timescale 1ns/1ps
`default_nettype none

module req_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             in_valid_i,
   output var  logic             in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output var  logic             out_valid_o,
   input  wire logic             out_ready_i,
   output var  logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wr_ptr;
      logic [PTR_W-1:0]            rd_ptr;
      logic [CNT_W-1:0]            cnt;
      logic                        in_ready;
      logic                        out_valid;
   } fifo_t;

   localparam fifo_t FIFO_RST = '{in_ready: 1'b1, default: '0};

   fifo_t st;
   fifo_t next_st;
   logic  push;
   logic  pop;

   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      return (p == PTR_LAST) ? '0 : PTR_W'(p + 1'b1);
   endfunction : bump

   assign in_ready_o  = st.in_ready;
   assign out_valid_o = st.out_valid;
   assign out_data_o  = st.mem[st.rd_ptr];
   assign push        = in_valid_i & st.in_ready;
   assign pop         = st.out_valid & out_ready_i;

   // pointer and count update, flags precomputed for the next cycle
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr_ptr] = in_data_i;
         next_st.wr_ptr         = bump(st.wr_ptr);
      end
      if (pop) begin
         next_st.rd_ptr = bump(st.rd_ptr);
      end
      if (push && !pop) begin
         next_st.cnt = CNT_W'(st.cnt + 1'b1);
      end else if (pop && !push) begin
         next_st.cnt = CNT_W'(st.cnt - 1'b1);
      end
      next_st.in_ready  = (next_st.cnt != CNT_FULL);
      next_st.out_valid = (next_st.cnt != '0);
   end

   // state register
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= FIFO_RST;
      end else begin
         st <= next_st;
      end
   end
endmodule : req_fifo

module narrow_bus_write_lane_steering #(
   parameter int FIFO_DEPTH = lane_steer_pkg::FIFO_DEPTH
) (
   input  wire logic                                   ref_clk_i,
   input  wire logic                                   sys_rst_i,
   input  wire logic                                   bus_wide_i,
   input  wire logic                                   wr_valid_i,
   output var  logic                                   wr_ready_o,
   input  wire logic [lane_steer_pkg::ADDR_W-1:0]      haddr_i,
   input  wire logic [lane_steer_pkg::SIZE_W-1:0]      hsize_i,
   input  wire logic [lane_steer_pkg::HDATA_W-1:0]     hwdata_i,
   input  wire logic                                   ext_ready_i,
   output var  logic                                   ext_valid_o,
   output var  logic [lane_steer_pkg::ADDR_W-1:0]      ext_addr_out_o,
   output var  logic [lane_steer_pkg::STRB_W-1:0]      ext_byte_lane_strobe_n_o,
   output var  logic [lane_steer_pkg::EXT_DATA_W-1:0]  ext_data_o
);
   import lane_steer_pkg::*;

   typedef struct packed {
      seq_state_t              state;
      logic                    wide;
      logic [SIZE_W-1:0]       size;
      logic [ADDR_W-1:0]       addr;
      logic [HDATA_W-1:0]      data;
      logic [ADDR_W-1:0]       idx;
      logic [CNT_W-1:0]        left;
      logic                    out_valid;
      logic [ADDR_W-1:0]       out_addr;
      logic [STRB_W-1:0]       out_strb_n;
      logic [EXT_DATA_W-1:0]   out_data;
   } seq_t;

   typedef struct packed {
      logic [ADDR_W-1:0]     addr;
      logic [STRB_W-1:0]     strb_n;
      logic [EXT_DATA_W-1:0] data;
   } xfer_t;

   localparam seq_t SEQ_RST = '{state: ST_IDLE, out_strb_n: STRB_NONE,
                                default: '0};

   seq_t               st;
   seq_t               next_st;
   logic               fifo_valid;
   logic               fifo_pop;
   logic [ENTRY_W-1:0] fifo_data;
   logic               fifo_wide;
   logic [SIZE_W-1:0]  fifo_size;
   logic [ADDR_W-1:0]  fifo_addr;
   logic [HDATA_W-1:0] fifo_hdata;
   logic               slot_free;
   xfer_t              cur;

   // number of external transfers for a size on the selected bus
   function automatic logic [CNT_W-1:0] xfer_count(input logic wide,
                                                   input logic [SIZE_W-1:0] size);
      logic [SIZE_W-1:0] s;
      s = (size > SIZE_DWORD) ? SIZE_DWORD : size;
      if (wide) begin
         s = (s == SIZE_BYTE) ? SIZE_BYTE : SIZE_W'(s - 1'b1);
      end
      return CNT_W'(CNT_ONE << s);
   endfunction : xfer_count

   // unit index of the first (highest) transfer
   function automatic logic [ADDR_W-1:0] first_idx(input logic wide,
                                                   input logic [SIZE_W-1:0] size,
                                                   input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] unit;
      logic [ADDR_W-1:0] span;
      unit = wide ? {1'b0, addr[ADDR_W-1:1]} : addr;
      span = ADDR_W'(xfer_count(wide, size) - CNT_ONE);
      return unit | span;
   endfunction : first_idx

   // lane, strobe and address mapping of one transfer
   function automatic xfer_t map_xfer(input logic wide,
                                      input logic [SIZE_W-1:0] size,
                                      input logic [ADDR_W-1:0] addr,
                                      input logic [HDATA_W-1:0] data,
                                      input logic [ADDR_W-1:0] idx);
      xfer_t x;
      x = '0;
      if (!wide) begin
         x.addr   = idx;
         x.data   = {LANE_PAD, data[{idx, 3'h0} +: BYTE_W]};
         x.strb_n = STRB_LOWER;
      end else begin
         x.addr = {1'b0, idx[ADDR_W-2:0]};
         x.data = data[{idx[ADDR_W-2:0], 4'h0} +: HALF_W];
         if (size == SIZE_BYTE) begin
            x.strb_n = addr[0] ? STRB_UPPER : STRB_LOWER;
         end else begin
            x.strb_n = STRB_BOTH;
         end
      end
      return x;
   endfunction : map_xfer

   req_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_req_fifo (
      .ref_clk_i   (ref_clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (wr_valid_i),
      .in_ready_o  (wr_ready_o),
      .in_data_i   ({bus_wide_i, hsize_i, haddr_i, hwdata_i}),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   // entry unpacking and handshake terms
   // load only once the output slot is free, so requests never run together
   assign {fifo_wide, fifo_size, fifo_addr, fifo_hdata} = fifo_data;
   assign fifo_pop  = (st.state == ST_IDLE) && slot_free;
   assign slot_free = !st.out_valid || ext_ready_i;
   assign cur       = map_xfer(st.wide, st.size, st.addr, st.data, st.idx);

   // request load and transfer sequencing
   always_comb begin
      next_st = st;
      if (slot_free) begin
         next_st.out_valid = 1'b0;
      end
      case (st.state)
         ST_IDLE: begin
            if (fifo_valid && slot_free) begin
               next_st.state = ST_BUSY;
               next_st.wide  = fifo_wide;
               next_st.size  = fifo_size;
               next_st.addr  = fifo_addr;
               next_st.data  = fifo_hdata;
               next_st.idx   = first_idx(fifo_wide, fifo_size, fifo_addr);
               next_st.left  = xfer_count(fifo_wide, fifo_size);
            end
         end
         ST_BUSY: begin
            if (slot_free) begin
               next_st.out_valid  = 1'b1;
               next_st.out_addr   = cur.addr;
               next_st.out_strb_n = cur.strb_n;
               next_st.out_data   = cur.data;
               next_st.idx        = ADDR_W'(st.idx - IDX_ONE);
               next_st.left       = CNT_W'(st.left - CNT_ONE);
               if (st.left == CNT_ONE) begin
                  next_st.state = ST_IDLE;
               end
            end
         end
         default: begin
            next_st = SEQ_RST;
         end
      endcase
   end

   // state register
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= SEQ_RST;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign ext_valid_o              = st.out_valid;
   assign ext_addr_out_o           = st.out_addr;
   assign ext_byte_lane_strobe_n_o = st.out_strb_n;
   assign ext_data_o               = st.out_data;
endmodule : narrow_bus_write_lane_steering
`default_nettype wire

// File: lane_steer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lane_steer_chk (
   input wire logic                                  ref_clk_i,
   input wire logic                                  sys_rst_i,
   input wire logic                                  bus_wide_i,
   input wire logic                                  wr_valid_i,
   input wire logic                                  wr_ready_o,
   input wire logic                                  ext_ready_i,
   input wire logic                                  ext_valid_o,
   input wire logic [lane_steer_pkg::ADDR_W-1:0]     ext_addr_out_o,
   input wire logic [lane_steer_pkg::STRB_W-1:0]     ext_byte_lane_strobe_n_o,
   input wire logic [lane_steer_pkg::EXT_DATA_W-1:0] ext_data_o
);
   import lane_steer_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   // a transfer taken, or one held back by the memory
   sequence take_s; ext_valid_o && ext_ready_i; endsequence
   sequence wait_s; ext_valid_o && !ext_ready_i; endsequence
   hold_valid_a: assert property (wait_s |=> ext_valid_o)
      else $error("transfer dropped while stalled");
   hold_lane_a: assert property (wait_s |=> $stable(ext_addr_out_o) &&
      $stable(ext_data_o) && $stable(ext_byte_lane_strobe_n_o))
      else $error("transfer changed while stalled");
   addr_descend_a: assert property (take_s ##1 ext_valid_o |->
      ext_addr_out_o == $past(ext_addr_out_o) - 3'h1)
      else $error("transfer address did not step down by one");
   narrow_strobe_a: assert property (ext_valid_o && !bus_wide_i |->
      ext_byte_lane_strobe_n_o == STRB_LOWER)
      else $error("narrow strobe not asserted");
   narrow_pad_a: assert property (ext_valid_o && !bus_wide_i |->
      ext_data_o[15:8] == LANE_PAD) else $error("narrow upper lane not zero");
   wide_addr_a: assert property (ext_valid_o && bus_wide_i |->
      !ext_addr_out_o[2]) else $error("wide address bit two set");
   wide_strobe_a: assert property (ext_valid_o && bus_wide_i |->
      ext_byte_lane_strobe_n_o != STRB_NONE) else $error("no lane strobed");
   ready_fall_a: assert property ($fell(wr_ready_o) |-> $past(wr_valid_i))
      else $error("ready fell without a request");
endmodule : lane_steer_chk
bind narrow_bus_write_lane_steering lane_steer_chk lane_steer_chk_inst (
   .ref_clk_i, .sys_rst_i, .bus_wide_i, .wr_valid_i, .wr_ready_o, .ext_ready_i,
   .ext_valid_o, .ext_addr_out_o, .ext_byte_lane_strobe_n_o, .ext_data_o);
`default_nettype wire

// File: lane_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module lane_mem_model (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [1:0]  mode_i,
   input  wire logic        wide_i,
   input  wire logic        valid_i,
   input  wire logic [2:0]  addr_i,
   input  wire logic [1:0]  strobe_n_i,
   input  wire logic [15:0] data_i,
   output logic             ready_o,
   output logic [63:0]      mem_o,
   output logic [23:0]      log_o,
   output logic [15:0]      cnt_o
);
   // mode 0 prompt, 1 ready every other cycle, 2 stalled
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ready_o <= 1'b0;
         mem_o <= '0;
         log_o <= '0;
         cnt_o <= '0;
      end else begin
         ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && !ready_o);
         if (valid_i && ready_o) begin
            cnt_o <= cnt_o + 16'h1;
            log_o <= {log_o[20:0], addr_i};
            // only strobed lanes land in memory
            if (!wide_i && !strobe_n_i[0]) begin
               mem_o[8*addr_i +: 8] <= data_i[7:0];
            end
            if (wide_i && !strobe_n_i[0]) begin
               mem_o[16*addr_i[1:0] +: 8] <= data_i[7:0];
            end
            if (wide_i && !strobe_n_i[1]) begin
               mem_o[16*addr_i[1:0]+8 +: 8] <= data_i[15:8];
            end
         end
      end
   end
endmodule : lane_mem_model
`default_nettype wire

// File: narrow_bus_write_lane_steering_tb.sv
`timescale 1ns/1ps
`default_nettype none
module narrow_bus_write_lane_steering_tb;
   import lane_steer_pkg::*;
   logic ref_clk_i, sys_rst_i, bus_wide_i, wr_valid_i, wr_ready_o;
   logic ext_ready_i, ext_valid_o;
   logic [2:0]  haddr_i, hsize_i, ext_addr_out_o;
   logic [63:0] hwdata_i, mem, exp_mem;
   logic [1:0]  ext_byte_lane_strobe_n_o, mode;
   logic [15:0] ext_data_o, cnt, exp_cnt;
   logic [23:0] alog, exp_log;
   int          fail_count, total_checks, cycles;
   narrow_bus_write_lane_steering #(.FIFO_DEPTH(8))
      narrow_bus_write_lane_steering_inst (.ref_clk_i, .sys_rst_i,
      .bus_wide_i, .wr_valid_i, .wr_ready_o, .haddr_i, .hsize_i, .hwdata_i,
      .ext_ready_i, .ext_valid_o, .ext_addr_out_o, .ext_byte_lane_strobe_n_o,
      .ext_data_o);
   lane_mem_model lane_mem_model_inst (.ref_clk_i, .sys_rst_i, .mode_i(mode),
      .wide_i(bus_wide_i), .valid_i(ext_valid_o), .addr_i(ext_addr_out_o),
      .strobe_n_i(ext_byte_lane_strobe_n_o), .data_i(ext_data_o),
      .ready_o(ext_ready_i), .mem_o(mem), .log_o(alog), .cnt_o(cnt));
   task automatic check(input string what, input logic [63:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out;
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   // hand one request over and work out the transfers it must make
   task automatic push(input logic w, input logic [2:0] a, s,
                       input logic [63:0] d);
      int nb, n, base;
      logic [2:0] top;
      nb = 1 << s;
      base = a & ~(nb - 1);
      n = (w && nb > 1) ? nb / 2 : nb;
      top = 3'((base + nb - 1) >> w);
      for (int k = base; k < base + nb; k++) exp_mem[8*k +: 8] = d[8*k +: 8];
      for (int k = 0; k < n; k++) exp_log = {exp_log[20:0], 3'(top - k)};
      exp_cnt = exp_cnt + 16'(n);
      @(posedge ref_clk_i);
      bus_wide_i <= w;
      haddr_i <= a;
      hsize_i <= s;
      hwdata_i <= d;
      wr_valid_i <= 1'b1;
      do @(posedge ref_clk_i); while (wr_ready_o !== 1'b1);
      wr_valid_i <= 1'b0;
   endtask : push
   // wait for the memory to see every transfer, then compare
   task automatic settle;
      for (int i = 0; i < 300 && cnt !== exp_cnt; i++) @(posedge ref_clk_i);
      check("transfer count", 64'(cnt), 64'(exp_cnt));
      check("memory", mem, exp_mem);
      check("address order", 64'(alog), 64'(exp_log));
   endtask : settle
   // every size at every aligned address on one bus width
   task automatic t_sweep(input logic w, input logic [1:0] m);
      mode <= m;
      for (int s = 0; s < 4; s++) begin
         for (int a = 0; a < 8; a += 1 << s) begin
            push(w, 3'(a), 3'(s), 64'hf7e6d5c4b3a29180 ^ {8{8'(a*3+s*29+1)}});
            settle();
         end
      end
   endtask : t_sweep
   // memory stalls while requests pile up until the queue refuses
   task automatic t_fill;
      mode <= 2'h2;
      for (int i = 0; i < 9; i++) push(1'b0, 3'(i), 3'h0, {8{8'(i + 64)}});
      @(posedge ref_clk_i);
      check("ready when full", 64'(wr_ready_o), 64'h0);
      mode <= 2'h1;
      push(1'b0, 3'h1, 3'h0, {8{8'h5a}});
      settle();
   endtask : t_fill
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   // timeout ceiling
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      {sys_rst_i, bus_wide_i, wr_valid_i, haddr_i, hsize_i} = 9'h100;
      {hwdata_i, exp_mem, exp_log, exp_cnt, mode} = '0;
      {fail_count, total_checks, cycles} = '0;
      repeat (2) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      check("idle strobe", 64'(ext_byte_lane_strobe_n_o), 64'h3);
      check("ready after reset", 64'(wr_ready_o), 64'h1);
      t_sweep(1'b0, 2'h1);
      t_sweep(1'b1, 2'h0);
      t_fill();
      close_out();
   end
endmodule : narrow_bus_write_lane_steering_tb
`default_nettype wire
